// ### rtl/dbc_defines.svh
/*
 * Constants of the dynamic brake chopper controller: register indices,
 * reset values, legal ranges and timing.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// ****************************************************************
// register word indices
// ****************************************************************
`define DBC_A_CTRL   4'h0
`define DBC_A_RES    4'h1
`define DBC_A_RATED  4'h2
`define DBC_A_OVR    4'h3
`define DBC_A_STAT   4'h4
`define DBC_A_AREA   4'h5
`define DBC_A_THR    4'h6
`define DBC_A_ISTAT  4'h7
`define DBC_A_IMASK  4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define DBC_B_EN       0
`define DBC_B_EV_ON    0
`define DBC_B_EV_FORCE 1
`define DBC_B_EV_REFUSE 2

// ****************************************************************
// reset values and ranges (resistance 0.01 ohm, power 0.01 kW,
// overrating 0.01, voltage 0.1 V)
// ****************************************************************
`define DBC_EN_RST     1'h1
`define DBC_RES_RST    17'h02710
`define DBC_RES_MIN    17'h00001
`define DBC_RES_MAX    17'h186a0
`define DBC_RATED_RST  16'h000a
`define DBC_RATED_MIN  16'h000a
`define DBC_RATED_MAX  16'hc738
`define DBC_OVR_RST    12'h9c4
`define DBC_OVR_MIN    12'h064
`define DBC_OVR_MAX    12'hfa0
`define DBC_THR_BASE   16'h1dd8
`define DBC_THR_SPAN   16'h005a
`define DBC_RATED_W    20'h0000a
`define DBC_AREA_SCALE 40'h64

// ****************************************************************
// timing
// ****************************************************************
`define DBC_CLK_NS     10
`define DBC_SAMPLE_NS  1000000
`define DBC_SAMPLE_CYC (`DBC_SAMPLE_NS / `DBC_CLK_NS)

`endif

// ### rtl/dbc_pkg.sv
/*
 * Types of the dynamic brake chopper controller.
 * Assumes dbc_defines.svh is available for constants.
 */
package dbc_pkg;

    // sequence of one sample period
    typedef enum logic [2:0] {
        ST_IDLE,   // waiting for the millisecond tick
        ST_POW,    // power division running
        ST_ACC,    // overload area updated
        ST_THR,    // threshold division running
        ST_CMP     // compare and drive the switch
    } dbc_state_t;

    // whole state of the top module
    typedef struct packed {
        dbc_state_t  st;
        logic [31:0] cnt;
        logic        en;
        logic [16:0] res;
        logic [15:0] rated;
        logic [11:0] ovr;
        logic [15:0] vd;
        logic [31:0] pw;
        logic [39:0] area;
        logic [39:0] limit;
        logic [15:0] thr;
        logic        forced;
        logic        sw;
        logic        freeze;
        logic [2:0]  istat;
        logic [2:0]  imask;
        logic        irq;
        logic [31:0] rdata;
        logic        go;
        logic [47:0] dvd;
        logic [39:0] dvs;
    } dbc_regs_t;

    // state of the divider
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  cnt;
        logic [40:0] rem;
        logic [47:0] quot;
    } dbc_div_t;

endpackage

// ### rtl/dbc_div_if.sv
/*
 * Request and answer of the shared divider.
 * Assumes one master starts a division only while busy is low.
 */
`timescale 1ns/1ns
interface dbc_div_if #(
    parameter int DW = 48,
    parameter int VW = 40
);
    logic          go;        // one-cycle start
    logic [DW-1:0] dividend;  // held while busy
    logic [VW-1:0] divisor;   // held while busy, nonzero
    logic          busy;      // division running
    logic          done;      // one-cycle, quot valid
    logic [DW-1:0] quot;      // quotient

    modport master (output go, dividend, divisor, input busy, done, quot);
    modport slave  (input go, dividend, divisor, output busy, done, quot);
endinterface

// ### rtl/dbc_sync3.sv
/*
 * Three-stage synchroniser for a slow level from a pin.
 * Assumes the level is stable for several clocks; the output
 * changes once stages two and three agree.
 */
`timescale 1ns/1ns
module dbc_sync3 (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [3:0] q_q;  // three stages and the held level
    logic [3:0] q_d;

    // shift; the first stage feeds only the second
    always_comb begin
        q_d = {q_q[3], q_q[1:0], din};
        if (q_q[1] == q_q[2]) begin
            q_d[3] = q_q[2];
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q_q <= 4'h0;
        end else begin
            q_q <= q_d;
        end
    end

    assign dout = q_q[3];
endmodule // dbc_sync3

// ### rtl/dbc_div.sv
/*
 * Restoring unsigned divider, one quotient bit per clock.
 * Assumes a nonzero divisor held stable while busy.
 */
`timescale 1ns/1ns
module dbc_div
    import dbc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    dbc_div_if.slave  dv
);
    dbc_div_t s_q;  // registered state
    dbc_div_t s_d;  // next state
    logic [40:0] trial;  // shifted remainder

    // one step per clock; done is a single-cycle pulse
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        trial = {s_q.rem[39:0], s_q.quot[47]};
        if (dv.go && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt  = 6'h00;
            s_d.rem  = 41'h0;
            s_d.quot = dv.dividend;
        end else if (s_q.busy) begin
            s_d.quot = {s_q.quot[46:0], 1'b0};
            s_d.rem  = trial;
            if (trial >= {1'b0, dv.divisor}) begin
                s_d.rem     = trial - {1'b0, dv.divisor};
                s_d.quot[0] = 1'b1;
            end
            s_d.cnt = s_q.cnt + 6'h01;
            // last of 48 steps
            if (s_q.cnt == 6'h2f) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dv.busy = s_q.busy;
    assign dv.done = s_q.done;
    assign dv.quot = s_q.quot;
endmodule // dbc_div

// ### rtl/dbc_top.sv
/*
 * Dynamic brake chopper controller: samples the dc link voltage each
 * millisecond, drives the brake switch, tracks resistor overload and
 * freezes the setpoint ramp while braking.
 * Assumes vdc_dv comes from sense logic on ref_clk (0.1 V units) and
 * drive_stopped is an asynchronous level from the drive sequencer.
 */
// Operation
// - sample dc link each millisecond, update switch
// - enable gates braking, default on, always writable
// - resistance 0.01..1000 ohm, default 100, stopped only
// - rated power 0.10..510 kW, default 0.10, stopped only
// - overrating 1..40, default 25, stopped only
// - braking-active status read-only, shows switch state
// - monitoring runs regardless of output stage
// - power above rating times time accumulates
// - area at overrating limit forces switch off
// - threshold 764V rising linearly to 773V
// - freeze output while voltage braking active
`timescale 1ns/1ns
`include "dbc_defines.svh"
module dbc_top
    import dbc_pkg::*;
#(
    parameter int MS_CYCLES = `DBC_SAMPLE_CYC  // clocks per sample
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [15:0] vdc_dv,
    input  wire logic        drive_stopped,
    output logic             brake_sw,
    output logic             ramp_freeze,
    output logic             irq
);
    // ****************************************************************
    // checks
    // ****************************************************************
    // the divider needs two 48-step passes inside one period
    if (MS_CYCLES < 128) begin : g_chk
        $error("MS_CYCLES too small for two divisions");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    dbc_regs_t   s_q;       // registered state
    dbc_regs_t   s_d;       // next state
    logic        stopped;   // synchronised stop level
    logic [19:0] rated_w;   // rated power in watts
    logic [31:0] excess;    // power above or below rating
    logic [11:0] ovr_x;     // overrating minus one
    logic [2:0]  ev;        // events this cycle
    logic [2:0]  clr;       // software clear mask

    dbc_div_if #(.DW(48), .VW(40)) div_if ();

    // ****************************************************************
    // helpers
    // ****************************************************************
    // range test shared by the three limited settings
    function automatic logic in_rng(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (v >= lo) && (v <= hi);
    endfunction

    // ****************************************************************
    // sub blocks
    // ****************************************************************
    // stop level crosses from the sequencer clock
    dbc_sync3 u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (drive_stopped),
        .dout    (stopped)
    );

    // one divider serves power and threshold in turn
    dbc_div u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .dv      (div_if.slave)
    );

    assign div_if.go       = s_q.go;
    assign div_if.dividend = s_q.dvd;
    assign div_if.divisor  = s_q.dvs;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d      = s_q;
        s_d.go   = 1'b0;
        ev       = 3'h0;
        clr      = 3'h0;
        rated_w  = 20'(s_q.rated * `DBC_RATED_W);
        ovr_x    = s_q.ovr - `DBC_OVR_MIN;
        excess   = 32'h0;

        // read data stands only in the cycle after the strobe
        s_d.rdata = 32'h0;
        if (rd) begin
            case (addr)
                `DBC_A_CTRL:  s_d.rdata = {31'h0, s_q.en};
                `DBC_A_RES:   s_d.rdata = {15'h0, s_q.res};
                `DBC_A_RATED: s_d.rdata = {16'h0, s_q.rated};
                `DBC_A_OVR:   s_d.rdata = {20'h0, s_q.ovr};
                `DBC_A_STAT:  s_d.rdata = {28'h0, s_q.forced, s_q.freeze,
                                           s_q.sw, stopped};
                `DBC_A_AREA:  s_d.rdata = s_q.area[39:8];
                `DBC_A_THR:   s_d.rdata = {16'h0, s_q.thr};
                `DBC_A_ISTAT: s_d.rdata = {29'h0, s_q.istat};
                `DBC_A_IMASK: s_d.rdata = {29'h0, s_q.imask};
                default:      s_d.rdata = 32'h0;  // unmapped reads zero
            endcase
        end

        // register writes
        if (wr) begin
            case (addr)
                `DBC_A_CTRL: s_d.en = wdata[`DBC_B_EN];
                // resistance only when stopped and in range
                `DBC_A_RES: begin
                    if (stopped && in_rng(wdata, 32'(`DBC_RES_MIN),
                                          32'(`DBC_RES_MAX))) begin
                        s_d.res = wdata[16:0];
                    end else begin
                        ev[`DBC_B_EV_REFUSE] = 1'b1;
                    end
                end
                // rated power only when stopped and in range
                `DBC_A_RATED: begin
                    if (stopped && in_rng(wdata, 32'(`DBC_RATED_MIN),
                                          32'(`DBC_RATED_MAX))) begin
                        s_d.rated = wdata[15:0];
                    end else begin
                        ev[`DBC_B_EV_REFUSE] = 1'b1;
                    end
                end
                // overrating only when stopped and in range
                `DBC_A_OVR: begin
                    if (stopped && in_rng(wdata, 32'(`DBC_OVR_MIN),
                                          32'(`DBC_OVR_MAX))) begin
                        s_d.ovr = wdata[11:0];
                    end else begin
                        ev[`DBC_B_EV_REFUSE] = 1'b1;
                    end
                end
                `DBC_A_ISTAT: clr = wdata[2:0];
                `DBC_A_IMASK: s_d.imask = wdata[2:0];
                // status and all others ignore writes
                default: ;
            endcase
        end

        // sample sequencer
        case (s_q.st)
            // runs whether or not the output stage is on
            ST_IDLE: begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (s_q.cnt == 32'(MS_CYCLES - 1)) begin
                    s_d.cnt = 32'h0;
                    s_d.vd  = vdc_dv;
                    s_d.dvd = {16'h0, 32'(vdc_dv * vdc_dv)};
                    s_d.dvs = {23'h0, s_q.res};
                    s_d.go  = 1'b1;
                    s_d.st  = ST_POW;
                end
            end
            // power over the last period: V squared over R, in watts
            ST_POW: begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (div_if.done) begin
                    s_d.pw = s_q.sw ? div_if.quot[31:0] : 32'h0;
                    // limit area in watt-ms: (ovr-1) x rated x 1 s
                    s_d.limit = 40'(ovr_x * s_q.rated * `DBC_AREA_SCALE);
                    if (s_d.pw > {12'h0, rated_w}) begin
                        excess   = s_d.pw - {12'h0, rated_w};
                        s_d.area = s_q.area + {8'h0, excess};
                    end else begin
                        excess   = {12'h0, rated_w} - s_d.pw;
                        s_d.area = (s_q.area > {8'h0, excess}) ?
                                   s_q.area - {8'h0, excess} : 40'h0;
                    end
                    s_d.st = ST_ACC;
                end
            end
            ST_ACC: begin
                s_d.cnt = s_q.cnt + 32'h1;
                s_d.forced = (s_q.area >= s_q.limit);
                if (s_q.limit == 40'h0) begin
                    // no overload allowed: threshold sits at the top
                    s_d.thr = `DBC_THR_BASE + `DBC_THR_SPAN;
                    s_d.st  = ST_CMP;
                end else begin
                    s_d.dvd = 48'(s_q.area * `DBC_THR_SPAN);
                    s_d.dvs = s_q.limit;
                    s_d.go  = 1'b1;
                    s_d.st  = ST_THR;
                end
            end
            // threshold 764 V plus 9 V times area over limit
            ST_THR: begin
                s_d.cnt = s_q.cnt + 32'h1;
                if (div_if.done) begin
                    s_d.thr = `DBC_THR_BASE +
                              ((div_if.quot > 48'(`DBC_THR_SPAN)) ?
                               `DBC_THR_SPAN : div_if.quot[15:0]);
                    s_d.st  = ST_CMP;
                end
            end
            ST_CMP: begin
                s_d.cnt = s_q.cnt + 32'h1;
                s_d.sw = s_q.en && !s_q.forced && (s_q.vd > s_q.thr);
                s_d.freeze = s_d.sw;
                s_d.st     = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase

        // events: switch turned on, force newly applied
        ev[`DBC_B_EV_ON]    = s_d.sw && !s_q.sw;
        ev[`DBC_B_EV_FORCE] = s_d.forced && !s_q.forced;
        // a new event beats a clear in the same cycle
        s_d.istat = (s_q.istat & ~clr) | ev;
        s_d.irq   = |(s_d.istat & s_d.imask);
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.st    <= ST_IDLE;
            s_q.en    <= `DBC_EN_RST;
            s_q.res   <= `DBC_RES_RST;
            s_q.rated <= `DBC_RATED_RST;
            s_q.ovr   <= `DBC_OVR_RST;
            s_q.thr   <= `DBC_THR_BASE;
            s_q.dvs   <= 40'h1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs straight from flops
    // ****************************************************************
    assign rdata       = s_q.rdata;
    assign brake_sw    = s_q.sw;
    assign ramp_freeze = s_q.freeze;
    assign irq         = s_q.irq;
endmodule // dbc_top

// ### tb/dbc_top_checker.sv
/* port checker of the brake chopper controller.
   assumes binding onto dbc_top and the sample counter starting at reset. */
`timescale 1ns/1ns
`include "dbc_defines.svh"
module dbc_top_checker #(
    parameter int MS_CYCLES = 200
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [15:0] vdc_dv,
    input wire logic        drive_stopped,
    input wire logic        brake_sw,
    input wire logic        ramp_freeze,
    input wire logic        irq
);
    // ****************************************************************
    // mirrors of internal state
    // ****************************************************************
    logic [31:0] cnt_q;   // phase inside the sample period
    logic [15:0] vcap_q;  // voltage taken at the tick
    logic        en_q;    // enable bit as last written
    logic [2:0]  mask_q;  // interrupt mask as last written
    // mirrors follow the port; the phase guess is the weak point
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q  <= 32'h0;
            vcap_q <= 16'h0;
            en_q   <= 1'b1;
            mask_q <= 3'h0;
        end else begin
            cnt_q <= (cnt_q == MS_CYCLES - 1) ? 32'h0 : cnt_q + 32'h1;
            if (cnt_q == MS_CYCLES - 1) begin
                vcap_q <= vdc_dv;
            end
            if (wr && addr == `DBC_A_CTRL) begin
                en_q <= wdata[0];
            end
            if (wr && addr == `DBC_A_IMASK) begin
                mask_q <= wdata[2:0];
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_freeze; ramp_freeze == brake_sw; endproperty
    property p_rd_idle; !rd |=> rdata == 32'h0; endproperty
    property p_unmapped; rd && addr > 4'h8 |=> rdata == 32'h0; endproperty
    property p_ctrl_rd; rd && addr == `DBC_A_CTRL |=> rdata == {31'h0, en_q}; endproperty
    property p_rise_thr; $rose(brake_sw) |-> vcap_q > 16'h1dd8; endproperty
    property p_rise_en; $rose(brake_sw) |-> en_q; endproperty
    property p_phase; $changed(brake_sw) |-> cnt_q inside {[50:150]}; endproperty
    property p_hold; $changed(brake_sw) |=> $stable(brake_sw) [*8]; endproperty
    property p_irq_mask; irq |-> mask_q != 3'h0; endproperty
    property p_irq_on; $rose(brake_sw) && mask_q[0] |-> ##[1:2] irq; endproperty
    a_freeze: assert property (p_freeze)
        else $error("freeze differs from switch");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("enable readback wrong");
    a_rise_thr: assert property (p_rise_thr)
        else $error("switch on at or below base level");
    a_rise_en: assert property (p_rise_en)
        else $error("switch on while disabled");
    a_phase: assert property (p_phase)
        else $error("switch changed outside update slot");
    a_hold: assert property (p_hold)
        else $error("switch not held");
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt with empty mask");
    a_irq_on: assert property (p_irq_on)
        else $error("unmasked switch event gave no interrupt");
    c_on: cover property ($rose(brake_sw));
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (rd && addr > 4'h8);
endmodule // dbc_top_checker

bind dbc_top dbc_top_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .vdc_dv(vdc_dv), .drive_stopped(drive_stopped),
    .brake_sw(brake_sw), .ramp_freeze(ramp_freeze), .irq(irq)
);

// ### tb/dbc_link_model.sv
/* dc link sense and brake resistor model.
   assumes the bench sets the link level; counts loaded clocks. */
`timescale 1ns/1ns
module dbc_link_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] level,    // link voltage, 0.1 V units
    input  wire logic        brake_sw, // resistor switch
    output logic      [15:0] vdc_dv,   // sensed voltage
    output logic      [31:0] on_cyc    // clocks with resistor loaded
);
    // sense path has one clock of delay, like a real converter
    always_ff @(posedge ref_clk) begin
        vdc_dv <= level;
        if (!rst_n) begin
            on_cyc <= 32'h0;
        end else if (brake_sw) begin
            on_cyc <= on_cyc + 32'h1;
        end
    end
endmodule // dbc_link_model

// ### tb/dbc_top_tb_top.sv
/* self-checking bench of the brake chopper controller.
   assumes the link model and a shortened sample period. */
`timescale 1ns/1ns
`include "dbc_defines.svh"
module dbc_top_tb_top;
    import dbc_pkg::*;
    localparam int MSC = 200;     // short period keeps the run brief
    logic        ref_clk = 1'b0;  // 100 MHz
    logic        rst_n, wr, rd, drive_stopped;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, on_cyc;
    logic [15:0] level, vdc_dv;
    logic        brake_sw, ramp_freeze, irq;
    int          miscompares = 0;
    int          cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    dbc_top #(.MS_CYCLES(MSC)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vdc_dv(vdc_dv),
        .drive_stopped(drive_stopped), .brake_sw(brake_sw),
        .ramp_freeze(ramp_freeze), .irq(irq));
    dbc_link_model u_link (.ref_clk(ref_clk), .rst_n(rst_n), .level(level),
        .brake_sw(brake_sw), .vdc_dv(vdc_dv), .on_cyc(on_cyc));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t word %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t pin %b wanted %b", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        chk_w(d, e);
    endtask
    task automatic wait_ms(input int n);
        repeat (n * MSC) @(posedge ref_clk);
        #1;
    endtask
    // stopped level passes a three-stage synchroniser
    task automatic set_stop(input logic s);
        @(posedge ref_clk);
        drive_stopped <= s;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic poll_stat(input int b, input logic v, output logic ok);
        logic [31:0] s;
        ok = 1'b0;
        for (int i = 0; i < 6000 && !ok; i++) begin
            rd_reg(`DBC_A_STAT, s);
            ok = (s[b] === v);
        end
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        rd_chk(`DBC_A_CTRL, 32'h1);
        rd_chk(`DBC_A_RES, 32'h2710);
        rd_chk(`DBC_A_RATED, 32'ha);
        rd_chk(`DBC_A_OVR, 32'h9c4);
        rd_chk(`DBC_A_THR, 32'h1dd8);
        rd_chk(`DBC_A_STAT, 32'h1);
        rd_chk(`DBC_A_IMASK, 32'h0);
        for (int a = 9; a < 16; a++) begin
            rd_chk(4'(a), 32'h0);
        end
    endtask
    task automatic t_refuse;
        logic [3:0]  ta [6] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3};
        logic [31:0] bad [6] = '{32'h0, 32'h186a1, 32'h9, 32'hc739, 32'h63, 32'hfa1};
        logic [31:0] lim [6] = '{32'h1, 32'h186a0, 32'ha, 32'hc738, 32'h64, 32'hfa0};
        logic [31:0] dft [6] = '{32'h2710, 32'h2710, 32'ha, 32'ha, 32'h9c4, 32'h9c4};
        set_stop(1'b0);
        wr_reg(`DBC_A_RES, 32'h1388);
        rd_chk(`DBC_A_RES, 32'h2710);
        rd_chk(`DBC_A_ISTAT, 32'h4);
        set_stop(1'b1);
        for (int i = 0; i < 6; i++) begin
            wr_reg(ta[i], bad[i]);
            rd_chk(ta[i], dft[i]);
            wr_reg(ta[i], lim[i]);
            rd_chk(ta[i], lim[i]);
            wr_reg(ta[i], dft[i]);
        end
    endtask
    // overload limit of 1000 is crossed by the first loaded sample
    task automatic t_force;
        logic ok;
        wr_reg(`DBC_A_ISTAT, 32'h7);
        wr_reg(`DBC_A_OVR, 32'h65);
        level <= 16'h1e14;
        poll_stat(3, 1'b1, ok);
        poll_stat(1, 1'b0, ok);
        chk_b(brake_sw, 1'b0);
        rd_chk(`DBC_A_THR, 32'h1e32);
        rd_chk(`DBC_A_AREA, 32'h16);
        rd_chk(`DBC_A_ISTAT, 32'h3);
        poll_stat(3, 1'b0, ok);
        chk_b(ok, 1'b1);
        level <= 16'h1b58;
        wait_ms(2);
        wr_reg(`DBC_A_OVR, 32'h9c4);
        wr_reg(`DBC_A_ISTAT, 32'h7);
    endtask
    task automatic t_thresh;
        level <= 16'h1dd8;
        wait_ms(3);
        chk_b(brake_sw, 1'b0);
        level <= 16'h1dd9;
        wait_ms(3);
        chk_b(brake_sw, 1'b1);
        chk_b(ramp_freeze, 1'b1);
        wr_reg(`DBC_A_STAT, 32'h0);
        rd_chk(`DBC_A_STAT, 32'h7);
        chk_b(irq, 1'b0);
        wr_reg(`DBC_A_IMASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1 chk_b(irq, 1'b1);
        wr_reg(`DBC_A_ISTAT, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1 chk_b(irq, 1'b0);
        wr_reg(`DBC_A_IMASK, 32'h0);
        level <= 16'h1b58;
        wait_ms(3);
        chk_b(ramp_freeze, 1'b0);
    endtask
    task automatic t_enable;
        logic [31:0] n;
        set_stop(1'b0);
        wr_reg(`DBC_A_CTRL, 32'h0);
        rd_chk(`DBC_A_CTRL, 32'h0);
        level <= 16'h1e14;
        wait_ms(3);
        chk_b(brake_sw, 1'b0);
        n = on_cyc;
        wait_ms(2);
        chk_w(on_cyc, n);
        wr_reg(`DBC_A_IMASK, 32'h1);
        wr_reg(`DBC_A_CTRL, 32'h1);
        wait_ms(3);
        chk_b(brake_sw, 1'b1);
        chk_b(irq, 1'b1);
        level <= 16'h1b58;
        wait_ms(3);
        chk_b(brake_sw, 1'b0);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        drive_stopped = 1'b1;
        level = 16'h1b58;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_reset();
        t_refuse();
        t_force();
        t_thresh();
        t_enable();
        test_done();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end
endmodule // dbc_top_tb_top
